// ===== rtl/cpr_readout.sv
/*
  Calibration pattern readout of a memory device: mode register capture,
  redirection of reads to the pattern register, latency pipe, burst
  engine and a classic Wishbone slave for configuration and status.
  Assumes commands synchronous to clk_i, one data beat per clock, and an
  array behind array_req_o that answers reads with the same latency.
*/
`timescale 1ns/10ps
`include "cpr_consts.svh"

module cpr_readout #(
  parameter int DQ_WIDTH = 8,
  parameter int MAX_RL = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Memory reset pin and command bus
  input wire logic mem_reset_n_i,
  input wire cpr_pkg::cpr_cmd_t cmd_i,
  // Register bus
  input wire cpr_pkg::cpr_wb_req_t wb_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  // Data pins
  output logic [DQ_WIDTH-1:0] dq_o,
  output logic dq_oe_o,
  output logic [2:0] beat_o,
  // Array access
  output cpr_pkg::cpr_cmd_t array_req_o,
  // Mode visibility
  output logic pattern_mode_o
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------

  typedef struct packed {
    logic mpr_en;
    logic [1:0] loc;
    cpr_pkg::cpr_bl_t mr0_bl;
    logic fill_copy;
    logic [4:0] rl;
    logic [15:0] pat_cnt;
    cpr_pkg::cpr_slot_t [MAX_RL-1:0] pipe;
    logic [7:0] pat;
    logic [2:0] last;
    logic dq_oe;
    logic [DQ_WIDTH-1:0] dq;
    logic [2:0] beat;
    cpr_pkg::cpr_cmd_t areq;
    logic ack;
    logic [31:0] rdat;
  } cpr_state_t;

  cpr_state_t st_r;
  cpr_state_t st_nxt;
  logic fill_bit;
  logic [DQ_WIDTH-1:0] fill_dq;
  logic rd_cmd;
  logic rd_pat;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------

  // Read or read with auto precharge
  function automatic logic is_read(input cpr_pkg::cpr_op_t op);
    return (op == cpr_pkg::CPR_OP_READ) || (op == cpr_pkg::CPR_OP_READ_AP);
  endfunction

  // Chopped burst decode from MR0 field and burst-chop bit
  function automatic logic is_chop(input cpr_pkg::cpr_bl_t bl, input logic bc);
    logic r;
    r = 1'b0;
    if (bl == cpr_pkg::CPR_BL_FIXED4) begin
      r = 1'b1;
    end else if (bl == cpr_pkg::CPR_BL_OTF) begin
      r = ~bc;
    end
    return r;
  endfunction

  // Pattern content by location
  function automatic logic [7:0] pat_of(input logic [1:0] loc);
    return (loc == 2'h0) ? `CPR_PAT_LOC0 : `CPR_PAT_RSVD;
  endfunction

  // Pipe tap for a latency, clamped to the pipe
  function automatic int tap_of(input logic [4:0] rl);
    int t;
    t = int'(rl) - 1;
    if (t < 0) begin
      t = 0;
    end else if (t > MAX_RL - 1) begin
      t = MAX_RL - 1;
    end
    return t;
  endfunction

  // Byte-lane merge of a write into an old word
  function automatic logic [31:0] wb_merge(input logic [31:0] old, input logic [31:0] dat,
                                           input logic [3:0] sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    return (old & ~m) | (dat & m);
  endfunction

  // ----------------------------------------------------------------------
  // Lane spreading of the next beat
  // ----------------------------------------------------------------------

  cpr_lane_fill #(
    .DQ_WIDTH(DQ_WIDTH)
  ) u_fill (
    .bit_i(fill_bit),
    .copy_i(st_r.fill_copy),
    .dq_o(fill_dq)
  );

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------

  // Command decode, latency pipe, burst engine and register bus
  always_comb begin
    cpr_pkg::cpr_slot_t slot;
    cpr_pkg::cpr_slot_t tap;
    logic [2:0] nb;
    logic [7:0] npat;
    logic [31:0] ctrl;
    logic wr;
    st_nxt = st_r;
    slot = '0;
    tap = '0;
    nb = 3'h0;
    npat = st_r.pat;
    ctrl = 32'h0000_0000;
    wr = 1'b0;
    rd_cmd = cmd_i.valid && is_read(cmd_i.op);
    rd_pat = rd_cmd && st_r.mpr_en;
    st_nxt.areq = '0;

    // Mode register set: MR3 enable and location, MR0 burst field
    if (cmd_i.valid && (cmd_i.op == cpr_pkg::CPR_OP_MRS)) begin
      if (cmd_i.ba[1:0] == `CPR_MR3) begin
        st_nxt.mpr_en = cmd_i.addr[`CPR_MR3_EN_BIT];
        st_nxt.loc = cmd_i.addr[`CPR_MR_BL_MSB:0];
      end else if (cmd_i.ba[1:0] == `CPR_MR0) begin
        st_nxt.mr0_bl = cpr_pkg::cpr_bl_t'(cmd_i.addr[`CPR_MR_BL_MSB:0]);
      end
    end else if (cmd_i.valid && !st_r.mpr_en) begin
      st_nxt.areq = cmd_i;
    end

    // Redirected read: auto precharge, bank and column bits dropped, except column bit 2, which picks the nibble of a chopped burst
    if (rd_pat) begin
      slot.valid = 1'b1;
      slot.chop = is_chop(st_r.mr0_bl, cmd_i.addr[`CPR_BC_BIT]);
      slot.upper = slot.chop & cmd_i.addr[`CPR_NIB_BIT];
      slot.loc = st_r.loc;
      st_nxt.pat_cnt = st_r.pat_cnt + 16'h0001;
    end

    // Latency pipe shared by all pattern reads
    for (int i = MAX_RL - 1; i > 0; i--) begin
      st_nxt.pipe[i] = st_r.pipe[i-1];
    end
    st_nxt.pipe[0] = slot;
    tap = st_r.pipe[tap_of(st_r.rl)];

    // Burst engine: start a new burst or step the current one
    if (tap.valid) begin
      nb = tap.upper ? 3'h4 : 3'h0;
      npat = pat_of(tap.loc);
      st_nxt.pat = npat;
      st_nxt.last = tap.chop ? (nb + 3'h3) : 3'h7;
      st_nxt.dq_oe = 1'b1;
      st_nxt.beat = nb;
    end else if (st_r.dq_oe && (st_r.beat != st_r.last)) begin
      nb = st_r.beat + 3'h1;
      st_nxt.beat = nb;
    end else begin
      st_nxt.dq_oe = 1'b0;
      st_nxt.beat = 3'h0;
    end
    fill_bit = npat[nb];
    st_nxt.dq = st_nxt.dq_oe ? fill_dq : '0;

    // Wishbone slave: one-cycle ack, dropped in the following cycle
    st_nxt.ack = wb_i.cyc && wb_i.stb && !st_r.ack;
    st_nxt.rdat = 32'h0000_0000;
    if (wb_i.cyc && wb_i.stb && !st_r.ack) begin
      wr = wb_i.we;
      ctrl[`CPR_CTRL_COPY_BIT] = st_r.fill_copy;
      ctrl[`CPR_CTRL_RL_MSB:`CPR_CTRL_RL_LSB] = st_r.rl;
      unique case (wb_i.adr)
        `CPR_OFS_CTRL: begin
          st_nxt.rdat = ctrl;
          if (wr) begin
            ctrl = wb_merge(ctrl, wb_i.dat, wb_i.sel);
            st_nxt.fill_copy = ctrl[`CPR_CTRL_COPY_BIT];
            st_nxt.rl = ctrl[`CPR_CTRL_RL_MSB:`CPR_CTRL_RL_LSB];
          end
        end
        `CPR_OFS_STATUS: begin
          st_nxt.rdat[`CPR_STAT_EN_BIT] = st_r.mpr_en;
          st_nxt.rdat[`CPR_STAT_LOC_MSB:`CPR_STAT_LOC_LSB] = st_r.loc;
          st_nxt.rdat[`CPR_STAT_BL_MSB:`CPR_STAT_BL_LSB] = st_r.mr0_bl;
          st_nxt.rdat[`CPR_STAT_BUSY_BIT] = st_r.dq_oe;
        end
        `CPR_OFS_COUNT: begin
          st_nxt.rdat = {16'h0000, st_r.pat_cnt};
          if (wr) begin
            // A read in the same cycle still counts
            st_nxt.pat_cnt = {15'h0000, rd_pat};
          end
        end
        default: begin
          st_nxt.rdat = 32'h0000_0000;
        end
      endcase
    end

    // Memory reset pin: mode, pipe and data path back to normal
    if (!mem_reset_n_i) begin
      st_nxt.mpr_en = 1'b0;
      st_nxt.loc = 2'h0;
      st_nxt.mr0_bl = cpr_pkg::CPR_BL_FIXED8;
      st_nxt.pipe = '0;
      st_nxt.dq_oe = 1'b0;
      st_nxt.dq = '0;
      st_nxt.beat = 3'h0;
      st_nxt.areq = '0;
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------

  // Synchronous reset to constants
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
      st_r.rl <= `CPR_RL_RST;
      st_r.fill_copy <= `CPR_COPY_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register
  assign wb_ack_o = st_r.ack;
  assign wb_dat_o = st_r.rdat;
  assign dq_o = st_r.dq;
  assign dq_oe_o = st_r.dq_oe;
  assign beat_o = st_r.beat;
  assign array_req_o = st_r.areq;
  assign pattern_mode_o = st_r.mpr_en;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------

  default clocking cb @(posedge clk_i);
  endclocking
  // Memory reset cuts bursts short on purpose, so it also cancels attempts
  default disable iff (rst_i || !mem_reset_n_i);

  // Helper terms for the properties
  logic mrs3;
  logic full_burst_start;
  logic launch;
  assign mrs3 = cmd_i.valid && (cmd_i.op == cpr_pkg::CPR_OP_MRS) && (cmd_i.ba[1:0] == `CPR_MR3);
  assign full_burst_start = st_r.dq_oe && (st_r.beat == 3'h0) && (st_r.last == 3'h7);
  assign launch = st_r.pipe[tap_of(st_r.rl)].valid;

  // Beat orders of the burst kinds
  sequence upper_nibble_s;
    beat_o == 3'h4 ##1 beat_o == 3'h5 ##1 beat_o == 3'h6 ##1 beat_o == 3'h7;
  endsequence

  sequence lower_nibble_s;
    beat_o == 3'h1 ##1 beat_o == 3'h2 ##1 beat_o == 3'h3;
  endsequence

  sequence full_burst_s;
    beat_o == 3'h1 ##1 beat_o == 3'h2 ##1 beat_o == 3'h3 ##1 beat_o == 3'h4
      ##1 beat_o == 3'h5 ##1 beat_o == 3'h6 ##1 beat_o == 3'h7;
  endsequence

  mode_enable_a: assert property (mrs3 && mem_reset_n_i |=>
    pattern_mode_o == $past(cmd_i.addr[`CPR_MR3_EN_BIT]))
    else $error("pattern mode does not follow MR3 bit 2");

  mode_hold_a: assert property (!mrs3 |=> pattern_mode_o == $past(pattern_mode_o))
    else $error("pattern mode changed without a mode register set");

  reset_clear_a: assert property (disable iff (rst_i)
    !mem_reset_n_i |=> !pattern_mode_o && !dq_oe_o)
    else $error("memory reset did not clear pattern mode");

  read_redirect_a: assert property (rd_pat |=> !array_req_o.valid && st_r.pipe[0].valid)
    else $error("pattern mode read reached the array");

  pattern_drop_a: assert property (st_r.mpr_en && cmd_i.valid |=> !array_req_o.valid)
    else $error("command reached the array in pattern mode");

  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("register bus ack longer than one cycle");

  idle_quiet_a: assert property (!dq_oe_o |-> dq_o == '0 && beat_o == 3'h0)
    else $error("data pins not quiet outside a burst");

  normal_read_a: assert property (rd_cmd && !st_r.mpr_en && mem_reset_n_i |=>
    array_req_o.valid && (array_req_o.op == $past(cmd_i.op)))
    else $error("normal read not passed to the array");

  burst_launch_a: assert property (st_r.pipe[tap_of(st_r.rl)].valid && mem_reset_n_i
    |=> dq_oe_o)
    else $error("pattern burst late after read latency");

  upper_chop_a: assert property ($rose(dq_oe_o) && beat_o == 3'h4 && mem_reset_n_i
    |-> upper_nibble_s ##1 (!dq_oe_o || $past(launch)))
    else $error("upper nibble chop out of order");

  lower_chop_a: assert property ($rose(dq_oe_o) && beat_o == 3'h0 && st_r.last == 3'h3
    |=> lower_nibble_s ##1 (!dq_oe_o || $past(launch)))
    else $error("lower nibble chop out of order");

  full_order_a: assert property ($rose(dq_oe_o) && full_burst_start && mem_reset_n_i
    |=> full_burst_s)
    else $error("full burst beats out of order");

  alt_pattern_a: assert property (dq_oe_o && st_r.pat == `CPR_PAT_LOC0
    |-> dq_o[0] == beat_o[0])
    else $error("location 00 pattern not alternating");

  lane_fill_a: assert property (dq_oe_o |->
    dq_o[1] == (dq_o[0] & st_r.fill_copy) && dq_o[DQ_WIDTH-1] == dq_o[1]
    && dq_o[((DQ_WIDTH-1)/8)*8] == dq_o[0])
    else $error("data pins do not copy or zero the pattern bit");

endmodule

// ===== rtl/cpr_consts.svh
/*
  Constants of the calibration pattern readout block: register offsets,
  field positions, reset values and command address bit positions.
  Assumes inclusion by bare name from the design files of this block.
*/

`ifndef CPR_CONSTS_SVH
`define CPR_CONSTS_SVH

// ----------------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------------
`define CPR_OFS_CTRL 8'h00
`define CPR_OFS_STATUS 8'h04
`define CPR_OFS_COUNT 8'h08

// ----------------------------------------------------------------------
// Control register fields and reset values
// ----------------------------------------------------------------------
`define CPR_CTRL_COPY_BIT 0
`define CPR_CTRL_RL_LSB 4
`define CPR_CTRL_RL_MSB 8
`define CPR_RL_RST 5'h05
`define CPR_COPY_RST 1'h1

// ----------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------
`define CPR_STAT_EN_BIT 0
`define CPR_STAT_LOC_LSB 1
`define CPR_STAT_LOC_MSB 2
`define CPR_STAT_BL_LSB 3
`define CPR_STAT_BL_MSB 4
`define CPR_STAT_BUSY_BIT 5

// ----------------------------------------------------------------------
// Mode register selection and command address bits
// ----------------------------------------------------------------------
`define CPR_MR0 2'h0
`define CPR_MR3 2'h3
`define CPR_MR3_EN_BIT 2
`define CPR_MR_BL_MSB 1
`define CPR_NIB_BIT 2
`define CPR_BC_BIT 12

// ----------------------------------------------------------------------
// Pattern contents per location
// ----------------------------------------------------------------------
`define CPR_PAT_LOC0 8'hAA
`define CPR_PAT_RSVD 8'h00

`endif

// ===== rtl/cpr_pkg.sv
/*
  Types of the calibration pattern readout block: command bus, bus
  request, latency slot and mode register zero burst field.
  Assumes nothing of its surroundings.
*/
package cpr_pkg;

  // ----------------------------------------------------------------------
  // Decoded commands on the command bus
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    CPR_OP_NOP, CPR_OP_MRS, CPR_OP_ACT, CPR_OP_READ, CPR_OP_READ_AP,
    CPR_OP_WRITE, CPR_OP_WRITE_AP, CPR_OP_PRE, CPR_OP_REF, CPR_OP_OTHER
  } cpr_op_t;

  // Mode register zero burst length field, in field code order
  typedef enum logic [1:0] {
    CPR_BL_FIXED8, CPR_BL_OTF, CPR_BL_FIXED4, CPR_BL_RSVD
  } cpr_bl_t;

  // One command with bank and address
  typedef struct packed {
    logic valid;
    cpr_op_t op;
    logic [2:0] ba;
    logic [15:0] addr;
  } cpr_cmd_t;

  // Wishbone request from the master
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } cpr_wb_req_t;

  // Pattern read waiting out its read latency
  typedef struct packed {
    logic valid;
    logic chop;
    logic upper;
    logic [1:0] loc;
  } cpr_slot_t;

endpackage

// ===== rtl/cpr_lane_fill.sv
/*
  Spreads the single pattern bit over the data pins of one part width.
  Assumes a width of 4, 8 or 16 and a registered consumer.
*/
`timescale 1ns/10ps

module cpr_lane_fill #(
  parameter int DQ_WIDTH = 8
) (
  // Pattern bit and fill choice
  input wire logic bit_i,
  input wire logic copy_i,
  // Spread data
  output logic [DQ_WIDTH-1:0] dq_o
);

  // ----------------------------------------------------------------------
  // Lane spreading
  // ----------------------------------------------------------------------

  // Bit zero of each byte lane carries the bit, the rest copy or zero
  always_comb begin
    for (int i = 0; i < DQ_WIDTH; i++) begin
      if ((i % 8) == 0) begin
        dq_o[i] = bit_i;
      end else begin
        dq_o[i] = bit_i & copy_i;
      end
    end
  end

endmodule

// ===== verification/cpr_ctrl_model.sv
/*
  Memory controller model that drives the command bus of the readout block.
  Assumes it shares clk_i with the device and that the bench calls its tasks.
*/
`timescale 1ns/10ps

module cpr_ctrl_model #(
  parameter int PRE_WAIT = 4,
  parameter int RECOVER_WAIT = 4
) (
  // Clock
  input wire logic clk_i,
  // Command bus
  output cpr_pkg::cpr_cmd_t cmd_o
);
  // ----------------------------------------------------------------------
  // Command issue
  // ----------------------------------------------------------------------
  initial cmd_o = '0;

  // One command for one cycle; the idle bus shows scrambled address bits
  task automatic send(input cpr_pkg::cpr_op_t op, input logic [2:0] ba,
                      input logic [15:0] adr);
    @(posedge clk_i);
    cmd_o <= '{1'h1, op, ba, adr};
    @(posedge clk_i);
    cmd_o <= '{1'h0, cpr_pkg::CPR_OP_NOP, ~ba, ~adr};
  endtask

  // Precharge all, wait, then enable with a location
  task automatic mpr_on(input logic [1:0] loc);
    send(cpr_pkg::CPR_OP_PRE, 3'h0, 16'h0400);
    repeat (PRE_WAIT) @(posedge clk_i);
    send(cpr_pkg::CPR_OP_MRS, 3'h3, {13'h0000, 1'h1, loc});
  endtask

  // Recovery wait, then disable
  task automatic mpr_off();
    repeat (RECOVER_WAIT) @(posedge clk_i);
    send(cpr_pkg::CPR_OP_MRS, 3'h3, 16'h0000);
  endtask

  // Pattern read; don't-care bank, precharge and column bits set on purpose
  task automatic pat_read(input cpr_pkg::cpr_op_t op, input logic bl8, input logic upper);
    send(op, 3'h5, {3'h0, bl8, 1'h0, 1'h1, 7'h5A, upper, 2'h0});
  endtask
endmodule

// ===== verification/cpr_readout_tb.sv
/*
  Self-checking bench of the calibration pattern readout block.
  Assumes the controller model of cpr_ctrl_model.sv and an eight-pin part.
*/
`timescale 1ns/10ps
`include "cpr_consts.svh"

module cpr_readout_tb;
  // ----------------------------------------------------------------------
  // Wiring
  // ----------------------------------------------------------------------
  localparam int RL = 5;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic mem_reset_n_i = 1'h1;
  cpr_pkg::cpr_cmd_t cmd;
  cpr_pkg::cpr_wb_req_t wb_i = '0;
  logic wb_ack_o;
  logic [31:0] wb_dat_o;
  logic [7:0] dq_o;
  logic dq_oe_o;
  logic [2:0] beat_o;
  cpr_pkg::cpr_cmd_t array_req_o;
  logic pattern_mode_o;
  int failures = 0;
  int check_count = 0;
  int cycles = 0;
  logic [31:0] rd;

  // Clock
  always #10 clk_i = ~clk_i;

  cpr_readout #(.DQ_WIDTH(8), .MAX_RL(16)) uut (.clk_i(clk_i), .rst_i(rst_i),
    .mem_reset_n_i(mem_reset_n_i), .cmd_i(cmd), .wb_i(wb_i), .wb_ack_o(wb_ack_o),
    .wb_dat_o(wb_dat_o), .dq_o(dq_o), .dq_oe_o(dq_oe_o), .beat_o(beat_o),
    .array_req_o(array_req_o), .pattern_mode_o(pattern_mode_o));

  cpr_ctrl_model mdl (.clk_i(clk_i), .cmd_o(cmd));

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Classic single cycle, held until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    @(posedge clk_i);
    wb_i <= '{1'h1, 1'h1, we, adr, 4'hF, dat};
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'h1);
    rd = wb_dat_o;
    wb_i <= '0;
  endtask

  // Waits out read latency, then compares every beat and the idle after
  task automatic burst(input int first, input int n, input logic live, input logic copy);
    logic b;
    #1;
    chk("no array req", array_req_o.valid, 1'h0);
    repeat (RL) @(posedge clk_i);
    for (int i = first; i < first + n; i++) begin
      #1;
      b = live & i[0];
      chk("dq_oe", dq_oe_o, 1'h1);
      chk("beat", beat_o, i[2:0]);
      chk("dq", dq_o, copy ? {8{b}} : {7'h00, b});
      @(posedge clk_i);
    end
    #1;
    chk("dq_oe end", dq_oe_o, 1'h0);
  endtask

  // Reconfigure burst field and location around a disable
  task automatic set_mode(input logic [15:0] field, input logic [1:0] loc);
    mdl.mpr_off();
    mdl.send(cpr_pkg::CPR_OP_MRS, 3'h0, field);
    mdl.mpr_on(loc);
  endtask

  task automatic array_read();
    mdl.send(cpr_pkg::CPR_OP_READ, 3'h1, 16'h1004);
    #1;
    chk("array req", array_req_o.valid, 1'h1);
    chk("array op", array_req_o.op, cpr_pkg::CPR_OP_READ);
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset();
    wb(1'h0, `CPR_OFS_CTRL, 32'h0);
    chk("ctrl", rd, 32'h0000_0051);
    wb(1'h0, `CPR_OFS_STATUS, 32'h0);
    chk("status", rd, 32'h0000_0000);
    wb(1'h0, 8'h0C, 32'h0);
    chk("unmapped", rd, 32'h0000_0000);
    chk("mode", pattern_mode_o, 1'h0);
    array_read();
    mdl.send(cpr_pkg::CPR_OP_WRITE, 3'h2, 16'h0008);
    #1;
    chk("array write", array_req_o.valid, 1'h1);
    $display("test reset and normal done");
  endtask

  task automatic t_full();
    mdl.mpr_on(2'h0);
    @(posedge clk_i);
    #1;
    chk("mode on", pattern_mode_o, 1'h1);
    wb(1'h1, `CPR_OFS_COUNT, 32'h0);
    mdl.pat_read(cpr_pkg::CPR_OP_READ_AP, 1'h1, 1'h0);
    burst(0, 8, 1'h1, 1'h1);
    mdl.pat_read(cpr_pkg::CPR_OP_READ, 1'h1, 1'h0);
    burst(0, 8, 1'h1, 1'h1);
    wb(1'h0, `CPR_OFS_COUNT, 32'h0);
    chk("count", rd, 32'h0000_0002);
    $display("test full burst done");
  endtask

  task automatic t_chop();
    set_mode(16'h0001, 2'h0);
    wb(1'h0, `CPR_OFS_STATUS, 32'h0);
    chk("status otf", rd, 32'h0000_0009);
    mdl.pat_read(cpr_pkg::CPR_OP_READ, 1'h0, 1'h0);
    burst(0, 4, 1'h1, 1'h1);
    mdl.pat_read(cpr_pkg::CPR_OP_READ_AP, 1'h0, 1'h1);
    burst(4, 4, 1'h1, 1'h1);
    mdl.pat_read(cpr_pkg::CPR_OP_READ, 1'h1, 1'h0);
    burst(0, 8, 1'h1, 1'h1);
    set_mode(16'h0002, 2'h0);
    mdl.pat_read(cpr_pkg::CPR_OP_READ, 1'h1, 1'h0);
    burst(0, 4, 1'h1, 1'h1);
    $display("test chop done");
  endtask

  task automatic t_copy_loc();
    wb(1'h1, `CPR_OFS_CTRL, 32'h0000_0050);
    set_mode(16'h0000, 2'h0);
    mdl.pat_read(cpr_pkg::CPR_OP_READ, 1'h1, 1'h0);
    burst(0, 8, 1'h1, 1'h0);
    set_mode(16'h0000, 2'h1);
    wb(1'h0, `CPR_OFS_STATUS, 32'h0);
    chk("status loc", rd, 32'h0000_0003);
    mdl.pat_read(cpr_pkg::CPR_OP_READ, 1'h1, 1'h0);
    burst(0, 8, 1'h0, 1'h0);
    wb(1'h1, `CPR_OFS_CTRL, 32'h0000_0051);
    $display("test copy and location done");
  endtask

  task automatic t_reset_off();
    set_mode(16'h0000, 2'h0);
    mdl.pat_read(cpr_pkg::CPR_OP_READ, 1'h1, 1'h0);
    repeat (RL + 2) @(posedge clk_i);
    mem_reset_n_i <= 1'h0;
    @(posedge clk_i);
    mem_reset_n_i <= 1'h1;
    #1;
    chk("reset dq_oe", dq_oe_o, 1'h0);
    chk("reset mode", pattern_mode_o, 1'h0);
    array_read();
    mdl.mpr_on(2'h0);
    mdl.mpr_off();
    @(posedge clk_i);
    #1;
    chk("mode off", pattern_mode_o, 1'h0);
    array_read();
    repeat (RL + 1) @(posedge clk_i);
    #1;
    chk("no pattern", dq_oe_o, 1'h0);
    $display("test device reset and disable done");
  endtask

  // ----------------------------------------------------------------------
  // Verdict and sequence
  // ----------------------------------------------------------------------
  task automatic results();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      results();
    end
  end

  // Main sequence; the settle time stands in for the lock wait
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'h0;
    repeat (20) @(posedge clk_i);
    t_reset();
    t_full();
    t_chop();
    t_copy_loc();
    t_reset_off();
    results();
  end
endmodule
